// File: fsg_top.sv
// Frame sync source: external pin relay or internal generator, routed onto back-channel slots.
//
// Behaviour
// - Source codes 0x8..0xF relay input pin 0..7; generator enable must be zero.
// - Routing value 0xAA sends sync on back-channel slots 0 and 1 of that port.
// - All four back channels launch the sync in the same clock cycle.
// - One tick is one back-channel frame: 30 bits, 600 ns at 50 Mbps.
// - At 2.5 Mbps one tick is 30 bits of 400 ns, 12 us.
// - Once enabled, pulses repeat without end until the generator is disabled.
// - Enable bit set selects internal generation; writing 0x01 to 0x18 starts it.
// - Control bits 7:4 choose the tick time base; 0 means port 0 frame.
// - Control bit 1 zero gives separate high/low counts; one gives 50/50 duty.
// - High and low counts are 16 bits, upper/lower bytes at 0x19..0x1C.
// - Control bit 2 sets output level at generation start; 0 starts low.
// - Per-port rate bits 2:0 of 0x58 set tick length; 110b means 50 Mbps.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_regs.svh"
module fsg_top (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire fsg_pkg::fsg_byte_t reg_addr_i,
   input wire fsg_pkg::fsg_byte_t reg_wdata_i,
   output fsg_pkg::fsg_byte_t reg_rdata_o,
   input wire fsg_pkg::fsg_byte_t gpio_i,
   output fsg_pkg::fsg_byte_t bc_gpio_o,
   output logic frame_sync_o
);
   import fsg_pkg::*;

   // ************************************************************
   // Reset release
   // ************************************************************
   logic [1:0] rst_pipe_reg;
   logic rst_n;
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_pipe_reg <= 2'h0;
      end else begin
         rst_pipe_reg <= {rst_pipe_reg[0], 1'h1};
      end
   end
   assign rst_n = rst_pipe_reg[1];

   // ************************************************************
   // Register file
   // ************************************************************
   fsg_byte_t ctl_reg, ctl_next, psel_reg, psel_next, rdata_reg, rdata_next;
   fsg_count_t hi_reg, hi_next, lo_reg, lo_next;
   logic [`FSG_PORTS-1:0][7:0] rate_reg, rate_next, route_reg, route_next;
   logic sync_reg, sync_next;
   fsg_gen_if gen_bus ();

   function automatic fsg_div_t tick_len(input logic [2:0] code);
      if (code == `FSG_RATE_50M) begin
         return 12'(`FSG_TICK_CYC_50M);
      end
      return 12'(`FSG_TICK_CYC_2M5);
   endfunction : tick_len

   function automatic logic route_hit(input logic [3:0] nibble);
      return nibble == `FSG_ROUTE_SYNC;
   endfunction : route_hit

   always_comb begin
      ctl_next = ctl_reg;
      hi_next = hi_reg;
      lo_next = lo_reg;
      psel_next = psel_reg;
      rate_next = rate_reg;
      route_next = route_reg;
      rdata_next = rdata_reg;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `FSG_ADDR_CTL: ctl_next = reg_wdata_i & `FSG_CTL_WMASK;
            `FSG_ADDR_HI_U: hi_next[15:8] = reg_wdata_i;
            `FSG_ADDR_HI_L: hi_next[7:0] = reg_wdata_i;
            `FSG_ADDR_LO_U: lo_next[15:8] = reg_wdata_i;
            `FSG_ADDR_LO_L: lo_next[7:0] = reg_wdata_i;
            `FSG_ADDR_PSEL: psel_next = reg_wdata_i;
            `FSG_ADDR_RATE: begin
               for (int p = 0; p < `FSG_PORTS; p++) begin
                  if (psel_reg[p]) begin
                     rate_next[p] = reg_wdata_i;
                  end
               end
            end
            `FSG_ADDR_ROUTE: begin
               for (int p = 0; p < `FSG_PORTS; p++) begin
                  if (psel_reg[p]) begin
                     route_next[p] = reg_wdata_i;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `FSG_ADDR_CTL: rdata_next = ctl_reg;
            `FSG_ADDR_HI_U: rdata_next = hi_reg[15:8];
            `FSG_ADDR_HI_L: rdata_next = hi_reg[7:0];
            `FSG_ADDR_LO_U: rdata_next = lo_reg[15:8];
            `FSG_ADDR_LO_L: rdata_next = lo_reg[7:0];
            `FSG_ADDR_STATUS: rdata_next = {6'h00, gen_bus.running, sync_reg};
            `FSG_ADDR_PSEL: rdata_next = psel_reg;
            `FSG_ADDR_RATE: rdata_next = rate_reg[psel_reg[`FSG_PSEL_RD_MSB:`FSG_PSEL_RD_LSB]];
            `FSG_ADDR_ROUTE: rdata_next = route_reg[psel_reg[`FSG_PSEL_RD_MSB:`FSG_PSEL_RD_LSB]];
            default: rdata_next = `FSG_RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctl_reg <= `FSG_RST_BYTE;
         hi_reg <= `FSG_RST_COUNT;
         lo_reg <= `FSG_RST_COUNT;
         psel_reg <= `FSG_RST_PSEL;
         rate_reg <= {`FSG_PORTS{`FSG_RST_RATE}};
         route_reg <= {`FSG_PORTS{`FSG_RST_BYTE}};
         rdata_reg <= `FSG_RST_BYTE;
      end else begin
         ctl_reg <= ctl_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
         psel_reg <= psel_next;
         rate_reg <= rate_next;
         route_reg <= route_next;
         rdata_reg <= rdata_next;
      end
   end
   assign reg_rdata_o = rdata_reg;

   // ************************************************************
   // Tick, source selection and back-channel launch
   // ************************************************************
   logic gen_en, ext_mode, restart, tick, en_d_reg, ext_reg, ext_next;
   logic [1:0] tb_port;
   fsg_div_t cur_len, div_reg, div_next;
   fsg_byte_t bc_reg, bc_next;

   assign gen_en = ctl_reg[`FSG_CTL_EN];
   // External relay only while the generator is off.
   assign ext_mode = ctl_reg[`FSG_CTL_SRC_MSB] && !gen_en;
   assign tb_port = ctl_reg[`FSG_CTL_SRC_MSB] ? 2'h0 : ctl_reg[`FSG_CTL_PORT_MSB:`FSG_CTL_SRC_LSB];
   // Rate code of the time base port.
   assign cur_len = tick_len(rate_reg[tb_port][`FSG_RATE_MSB:`FSG_RATE_LSB]);
   assign restart = gen_en && !en_d_reg;
   assign tick = (div_reg == `FSG_RST_DIV);

   always_comb begin
      div_next = (restart || tick) ? cur_len - 12'h001 : div_reg - 12'h001;
      ext_next = ext_reg;
      // Sample the pin once per frame.
      if (tick && ext_mode) begin
         ext_next = gpio_i[ctl_reg[`FSG_CTL_PIN_MSB:`FSG_CTL_SRC_LSB]];
      end
      sync_next = gen_en ? gen_bus.sync : (ext_mode && ext_reg);
      // Every routed slot loads the same level in one cycle.
      for (int p = 0; p < `FSG_PORTS; p++) begin
         bc_next[2*p] = route_hit(route_reg[p][3:0]) && sync_reg;
         bc_next[2*p+1] = route_hit(route_reg[p][7:4]) && sync_reg;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= `FSG_RST_DIV;
         en_d_reg <= 1'h0;
         ext_reg <= 1'h0;
         sync_reg <= 1'h0;
         bc_reg <= `FSG_RST_BYTE;
      end else begin
         div_reg <= div_next;
         en_d_reg <= gen_en;
         ext_reg <= ext_next;
         sync_reg <= sync_next;
         bc_reg <= bc_next;
      end
   end
   assign bc_gpio_o = bc_reg;
   assign frame_sync_o = sync_reg;

   assign gen_bus.en = gen_en;
   assign gen_bus.shape = ctl_reg[`FSG_CTL_SHAPE];
   assign gen_bus.start_lvl = ctl_reg[`FSG_CTL_START];
   assign gen_bus.tick = tick;
   assign gen_bus.hi = hi_reg;
   assign gen_bus.lo = lo_reg;

   fsg_pulse_gen u_gen (
      .clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .bus(gen_bus.gen)
   );

   // ************************************************************
   // Assertions
   // ************************************************************
   fsg_div_t gap_reg, len_d_reg;
   logic gap_ok_reg;
   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= `FSG_RST_DIV;
         len_d_reg <= `FSG_RST_DIV;
         gap_ok_reg <= 1'h0;
      end else begin
         gap_reg <= tick ? `FSG_RST_DIV : gap_reg + 12'h001;
         len_d_reg <= cur_len;
         gap_ok_reg <= (restart || cur_len != len_d_reg) ? 1'h0 : (tick ? 1'h1 : gap_ok_reg);
      end
   end

   property p_ext_sample;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (tick && ext_mode) |=> ext_reg == $past(gpio_i[ctl_reg[`FSG_CTL_PIN_MSB:`FSG_CTL_SRC_LSB]]);
   endproperty
   a_ext_sample: assert property (p_ext_sample) else $error("pin not sampled");

   property p_route;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (route_reg[1] == 8'haa && $stable(route_reg[1])) |=> bc_gpio_o[3:2] == {2{$past(sync_reg)}};
   endproperty
   a_route: assert property (p_route) else $error("routed slots wrong");

   property p_lockstep;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (route_reg[0] == route_reg[3]) |=> bc_gpio_o[1:0] == bc_gpio_o[7:6];
   endproperty
   a_lockstep: assert property (p_lockstep) else $error("ports skewed");

   property p_tick_fast;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (tick && gap_ok_reg && cur_len == len_d_reg && rate_reg[tb_port][2:0] == `FSG_RATE_50M)
      |-> gap_reg == 12'(`FSG_TICK_CYC_50M - 1);
   endproperty
   a_tick_fast: assert property (p_tick_fast) else $error("50 Mbps tick wrong");

   property p_tick_slow;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (tick && gap_ok_reg && cur_len == len_d_reg && rate_reg[tb_port][2:0] != `FSG_RATE_50M)
      |-> gap_reg == 12'(`FSG_TICK_CYC_2M5 - 1);
   endproperty
   a_tick_slow: assert property (p_tick_slow) else $error("2.5 Mbps tick wrong");

   property p_internal;
      @(posedge sys_clk_i) disable iff (!rst_n)
      gen_en |=> frame_sync_o == $past(gen_bus.sync);
   endproperty
   a_internal: assert property (p_internal) else $error("internal source not used");

   property p_timebase;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (gen_en && ctl_reg[`FSG_CTL_SRC_MSB:`FSG_CTL_SRC_LSB] == 4'h0)
      |-> cur_len == tick_len(rate_reg[0][2:0]);
   endproperty
   a_timebase: assert property (p_timebase) else $error("time base not port 0");

   property p_count_bytes;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (reg_wr_i && reg_addr_i == `FSG_ADDR_LO_U) |=> lo_reg[15:8] == $past(reg_wdata_i);
   endproperty
   a_count_bytes: assert property (p_count_bytes) else $error("count byte lost");

   c_ext_relay: cover property (@(posedge sys_clk_i) disable iff (!rst_n) tick && ext_mode);
   c_route_all: cover property (@(posedge sys_clk_i) disable iff (!rst_n) bc_gpio_o == 8'hff);
   c_start: cover property (@(posedge sys_clk_i) disable iff (!rst_n) restart);
endmodule : fsg_top
`default_nettype wire

// File: fsg_regs.svh
// Register offsets, field positions, reset values and timing counts of the frame sync generator.
`ifndef FSG_REGS_SVH
`define FSG_REGS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define FSG_ADDR_CTL 8'h18
`define FSG_ADDR_HI_U 8'h19
`define FSG_ADDR_HI_L 8'h1a
`define FSG_ADDR_LO_U 8'h1b
`define FSG_ADDR_LO_L 8'h1c
`define FSG_ADDR_STATUS 8'h1d
`define FSG_ADDR_PSEL 8'h4c
`define FSG_ADDR_RATE 8'h58
`define FSG_ADDR_ROUTE 8'h6e

// ************************************************************
// Fields
// ************************************************************
`define FSG_CTL_EN 0
`define FSG_CTL_SHAPE 1
`define FSG_CTL_START 2
`define FSG_CTL_SRC_LSB 4
`define FSG_CTL_SRC_MSB 7
`define FSG_CTL_PORT_MSB 5
`define FSG_CTL_PIN_MSB 6
`define FSG_CTL_WMASK 8'hf7
`define FSG_PSEL_RD_LSB 4
`define FSG_PSEL_RD_MSB 5
`define FSG_RATE_MSB 2
`define FSG_RATE_LSB 0
`define FSG_RATE_50M 3'h6
`define FSG_ROUTE_SYNC 4'ha
`define FSG_PORTS 4

// ************************************************************
// Reset values
// ************************************************************
`define FSG_RST_BYTE 8'h00
`define FSG_RST_PSEL 8'h01
`define FSG_RST_RATE 8'h06
`define FSG_RST_COUNT 16'h0000
`define FSG_RST_DIV 12'h000

// ************************************************************
// Timing
// ************************************************************
`define FSG_CLK_NS 5
`define FSG_FRAME_BITS 30
`define FSG_BIT_NS_50M 20
`define FSG_BIT_NS_2M5 400
`define FSG_TICK_CYC_50M ((`FSG_FRAME_BITS * `FSG_BIT_NS_50M) / `FSG_CLK_NS)
`define FSG_TICK_CYC_2M5 ((`FSG_FRAME_BITS * `FSG_BIT_NS_2M5) / `FSG_CLK_NS)

`endif

// File: fsg_pkg.sv
// Types shared by the frame sync generator modules.
`default_nettype none
package fsg_pkg;
   typedef logic [7:0] fsg_byte_t;
   typedef logic [15:0] fsg_count_t;
   typedef logic [11:0] fsg_div_t;
   typedef enum logic [1:0] {FSG_IDLE, FSG_HIGH, FSG_LOW} fsg_gen_state_e;
endpackage : fsg_pkg
`default_nettype wire

// File: fsg_gen_if.sv
// Connection between the sync control logic and the pulse generator.
`timescale 1ns/1ps
`default_nettype none
interface fsg_gen_if;
   logic en;
   logic shape;
   logic start_lvl;
   logic tick;
   fsg_pkg::fsg_count_t hi;
   fsg_pkg::fsg_count_t lo;
   logic sync;
   logic running;
   modport ctl (output en, output shape, output start_lvl, output tick, output hi, output lo,
                input sync, input running);
   modport gen (input en, input shape, input start_lvl, input tick, input hi, input lo,
                output sync, output running);
endinterface : fsg_gen_if
`default_nettype wire

// File: fsg_pulse_gen.sv
// High and low phase counter that shapes the internally generated sync pulse.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_regs.svh"
module fsg_pulse_gen (
   input wire logic clk_i,
   input wire logic rst_n_i,
   fsg_gen_if.gen bus
);
   import fsg_pkg::*;

   fsg_gen_state_e state_reg, state_next;
   fsg_count_t cnt_reg, cnt_next;
   logic sync_reg, sync_next;
   fsg_count_t hi_len_w, lo_len_w, half_w;

   // A zero count would stall the phase, so it lasts one tick.
   function automatic fsg_count_t phase_len(input logic shape, input fsg_count_t hi,
                                            input fsg_count_t lo, input logic high);
      fsg_count_t v;
      if (shape) begin
         v = 16'(({1'h0, hi} + {1'h0, lo}) >> 1);
      end else begin
         v = high ? hi : lo;
      end
      return (v == `FSG_RST_COUNT) ? 16'h0001 : v;
   endfunction : phase_len

   assign hi_len_w = phase_len(bus.shape, bus.hi, bus.lo, 1'h1);
   assign lo_len_w = phase_len(bus.shape, bus.hi, bus.lo, 1'h0);
   assign half_w = phase_len(1'h1, bus.hi, bus.lo, 1'h1);

   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         FSG_IDLE: begin
            if (bus.en) begin
               state_next = bus.start_lvl ? FSG_HIGH : FSG_LOW;
               cnt_next = bus.start_lvl ? hi_len_w : lo_len_w;
            end
         end
         FSG_HIGH, FSG_LOW: begin
            if (!bus.en) begin
               state_next = FSG_IDLE;
               cnt_next = `FSG_RST_COUNT;
            end else if (bus.tick) begin
               if (cnt_reg <= 16'h0001) begin
                  state_next = (state_reg == FSG_HIGH) ? FSG_LOW : FSG_HIGH;
                  cnt_next = (state_reg == FSG_HIGH) ? lo_len_w : hi_len_w;
               end else begin
                  cnt_next = cnt_reg - 16'h0001;
               end
            end
         end
         default: begin
            state_next = FSG_IDLE;
            cnt_next = `FSG_RST_COUNT;
         end
      endcase
      sync_next = (state_next == FSG_HIGH);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= FSG_IDLE;
         cnt_reg <= `FSG_RST_COUNT;
         sync_reg <= 1'h0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sync_reg <= sync_next;
      end
   end

   assign bus.sync = sync_reg;
   assign bus.running = (state_reg != FSG_IDLE);

   // ************************************************************
   // Assertions
   // ************************************************************
   property p_start_level;
      @(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == FSG_IDLE && bus.en) |=> (bus.sync == $past(bus.start_lvl)) && bus.running;
   endproperty
   a_start_level: assert property (p_start_level) else $error("start level wrong");

   property p_continuous;
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus.running && bus.en) ##1 bus.en |-> bus.running;
   endproperty
   a_continuous: assert property (p_continuous) else $error("generator stopped");

   property p_half;
      @(posedge clk_i) disable iff (!rst_n_i)
      (bus.shape && bus.en && bus.tick && state_reg == FSG_HIGH && cnt_reg == 16'h0001)
      |=> (state_reg == FSG_LOW) && (cnt_reg == $past(half_w)) && !bus.sync;
   endproperty
   a_half: assert property (p_half) else $error("half period wrong");

   property p_phase_len;
      @(posedge clk_i) disable iff (!rst_n_i)
      (!bus.shape && bus.en && bus.tick && state_reg == FSG_LOW && cnt_reg == 16'h0001)
      |=> (state_reg == FSG_HIGH) && (cnt_reg == $past(bus.hi) || $past(bus.hi) == 16'h0000)
          && bus.sync;
   endproperty
   a_phase_len: assert property (p_phase_len) else $error("high phase length wrong");

   c_high_to_low: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      state_reg == FSG_HIGH ##1 state_reg == FSG_LOW);
endmodule : fsg_pulse_gen
`default_nettype wire

// File: fsg_serializer_model.sv
// Behavioural model of one remote serializer recording rising edges on slot 0 of its two back-channel sync slots.
`timescale 1ns/1ps
`default_nettype none
module fsg_serializer_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [1:0] slot_i,
   output var logic [31:0] rise_cyc_o,
   output var logic [15:0] rise_cnt_o
);
   logic [31:0] cyc;
   logic slot_q;
   // ************************************************************
   // Receive
   // ************************************************************
   // Only rising edges matter to a sensor trigger, so the level between pulses is not kept.
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc <= 32'h0;
         slot_q <= 1'b0;
         rise_cyc_o <= 32'h0;
         rise_cnt_o <= 16'h0;
      end else begin
         cyc <= cyc + 32'h1;
         slot_q <= slot_i[0];
         if (slot_i[0] && !slot_q) begin
            rise_cyc_o <= cyc;
            rise_cnt_o <= rise_cnt_o + 16'h1;
         end
      end
   end
endmodule : fsg_serializer_model
`default_nettype wire

// File: fsg_top_bench.sv
// Self-checking testbench of the frame sync generator.
`timescale 1ns/1ps
`default_nettype none
`include "fsg_regs.svh"
module fsg_top_bench;
   import fsg_pkg::*;
   localparam int TF = 30 * 20 / 5;
   localparam int TS = 30 * 400 / 5;
   logic clk;
   logic nrst;
   logic wr;
   logic rd;
   logic fsync;
   fsg_byte_t addr;
   fsg_byte_t wdata;
   fsg_byte_t rdata;
   fsg_byte_t gpio;
   fsg_byte_t bc;
   logic [31:0] rise_cyc [4];
   logic [15:0] rise_cnt [4];
   int n_errors = 0;
   int total_checks = 0;
   fsg_top i_dut (.sys_clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .gpio_i(gpio),
      .bc_gpio_o(bc), .frame_sync_o(fsync));
   for (genvar p = 0; p < 4; p++) begin : g_ser
      fsg_serializer_model i_ser (.clk_i(clk), .rst_n_i(nrst), .slot_i(bc[2*p+1:2*p]),
         .rise_cyc_o(rise_cyc[p]), .rise_cnt_o(rise_cnt[p]));
   end
   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic check(input string w, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", w, e, s);
      end
   endtask : check
   task automatic wr_reg(input fsg_byte_t a, input fsg_byte_t d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   task automatic rd_check(input fsg_byte_t a, input fsg_byte_t e, input string w);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      check(w, 32'(rdata), 32'(e));
   endtask : rd_check
   task automatic set_counts(input logic [15:0] hi, input logic [15:0] lo);
      wr_reg(`FSG_ADDR_HI_U, hi[15:8]);
      wr_reg(`FSG_ADDR_HI_L, hi[7:0]);
      wr_reg(`FSG_ADDR_LO_U, lo[15:8]);
      wr_reg(`FSG_ADDR_LO_L, lo[7:0]);
   endtask : set_counts
   // A bounded wait, so a stuck output ends the count instead of the run.
   task automatic phase_len(input logic lvl, output int n);
      n = 0;
      while (fsync === lvl && n < 20000) begin
         @(negedge clk);
         n++;
      end
   endtask : phase_len
   task automatic wait_lvl(input logic lvl);
      int k;
      k = 0;
      while (fsync !== lvl && k < 20000) begin
         @(negedge clk);
         k++;
      end
   endtask : wait_lvl
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs();
      fsg_byte_t v [4] = '{8'h0a, 8'hd7, 8'h61, 8'ha0};
      for (int a = 0; a < 5; a++) rd_check(8'h18 + 8'(a), 8'h00, "count reset");
      rd_check(`FSG_ADDR_PSEL, 8'h01, "psel reset");
      rd_check(`FSG_ADDR_RATE, 8'h06, "rate reset");
      rd_check(`FSG_ADDR_ROUTE, 8'h00, "route reset");
      wr_reg(8'h30, 8'h5a);
      rd_check(8'h30, 8'h00, "unmapped");
      for (int a = 0; a < 4; a++) wr_reg(8'h19 + 8'(a), v[a]);
      for (int a = 0; a < 4; a++) rd_check(8'h19 + 8'(a), v[a], "count byte");
      wr_reg(`FSG_ADDR_CTL, 8'h08);
      rd_check(`FSG_ADDR_CTL, 8'h00, "ctl bit3");
      $display("test regs done");
   endtask : t_regs
   task automatic t_indep();
      int n;
      logic seen;
      wr_reg(`FSG_ADDR_PSEL, 8'h0f);
      wr_reg(`FSG_ADDR_ROUTE, 8'haa);
      wr_reg(`FSG_ADDR_RATE, 8'h06);
      set_counts(16'd2, 16'd3);
      wr_reg(`FSG_ADDR_CTL, 8'h05);
      wait_lvl(1'b1);
      @(negedge clk);
      check("bc high", 32'(bc), 32'hff);
      phase_len(1'b1, n);
      check("high len", n, 2 * TF - 1);
      @(negedge clk);
      check("bc low", 32'(bc), 32'h00);
      phase_len(1'b0, n);
      check("low len", n, 3 * TF - 1);
      phase_len(1'b1, n);
      check("2nd high", n, 2 * TF);
      for (int p = 1; p < 4; p++) check("skew", rise_cyc[p], rise_cyc[0]);
      check("rises", 32'(rise_cnt[3]), 32'h2);
      wr_reg(`FSG_ADDR_PSEL, 8'h02);
      wr_reg(`FSG_ADDR_ROUTE, 8'h0a);
      wait_lvl(1'b1);
      repeat (2) @(negedge clk);
      check("route p1", 32'(bc), 32'hf7);
      wr_reg(`FSG_ADDR_CTL, 8'h00);
      seen = 1'b0;
      repeat (2) @(negedge clk);
      repeat (6 * TF) begin
         @(negedge clk);
         seen = seen | (fsync !== 1'b0);
      end
      check("disabled", 32'(seen), 32'h0);
      wr_reg(`FSG_ADDR_CTL, 8'h01);
      phase_len(1'b0, n);
      check("start low", n, 3 * TF + 2);
      wr_reg(`FSG_ADDR_CTL, 8'h00);
      $display("test independent done");
   endtask : t_indep
   task automatic t_half();
      int n;
      set_counts(16'd2, 16'd5);
      wr_reg(`FSG_ADDR_CTL, 8'h07);
      wait_lvl(1'b1);
      phase_len(1'b1, n);
      check("half high", n, 3 * TF);
      phase_len(1'b0, n);
      check("half low", n, 3 * TF);
      wr_reg(`FSG_ADDR_CTL, 8'h00);
      $display("test half done");
   endtask : t_half
   task automatic t_slow();
      int n;
      wr_reg(`FSG_ADDR_PSEL, 8'h01);
      wr_reg(`FSG_ADDR_RATE, 8'h00);
      set_counts(16'd1, 16'd1);
      wr_reg(`FSG_ADDR_CTL, 8'h05);
      wait_lvl(1'b1);
      phase_len(1'b1, n);
      check("slow tick", n, TS);
      wr_reg(`FSG_ADDR_CTL, 8'h00);
      wr_reg(`FSG_ADDR_CTL, 8'h15);
      wait_lvl(1'b1);
      phase_len(1'b1, n);
      check("port1 base", n, TF);
      wr_reg(`FSG_ADDR_CTL, 8'h00);
      wr_reg(`FSG_ADDR_RATE, 8'h06);
      $display("test slow done");
   endtask : t_slow
   task automatic t_ext();
      int k;
      for (int p = 0; p < 8; p++) begin
         wr_reg(`FSG_ADDR_CTL, {4'(8 + p), 4'h0});
         gpio = ~(8'h01 << p);
         repeat (2 * TF + 4) @(negedge clk);
         check("pin off", 32'(fsync), 32'h0);
         gpio = 8'h01 << p;
         k = 0;
         while (fsync !== 1'b1 && k < 2 * TF) begin
            @(negedge clk);
            k++;
         end
         check("pin pace", 32'(k <= TF + 2), 32'h1);
         @(negedge clk);
         // Port 1 still routes slot 0 only, as the routing scenario left it.
         check("pin bc", 32'(bc), 32'hf7);
      end
      // The generator must win over a live external pin.
      wr_reg(`FSG_ADDR_CTL, 8'hf1);
      @(negedge clk);
      check("ext vs gen", 32'(fsync), 32'h0);
      wr_reg(`FSG_ADDR_CTL, 8'h00);
      gpio = 8'h00;
      $display("test external done");
   endtask : t_ext
   // ************************************************************
   // Run
   // ************************************************************
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      nrst = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      gpio = 8'h00;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      t_regs();
      t_indep();
      t_half();
      t_slow();
      t_ext();
      give_verdict();
   end
   // The span covers all scenarios, about eight thousand cycles, with a wide margin.
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      give_verdict();
   end
endmodule : fsg_top_bench
`default_nettype wire
